// *** logic/dbr_regs.sv ***
module dbr_regs #(
    parameter int NUM_IAC = dbr_pkg::NUM_IAC,
    parameter int NUM_DAC = dbr_pkg::NUM_DAC,
    parameter int NUM_DVC = dbr_pkg::NUM_DVC
) (
    input  wire logic                            clk_i,
    input  wire logic                            reset_n_i,
    // Move-to / move-from special register port
    input  wire logic                            spr_valid_i,
    input  wire logic                            spr_write_i,
    input  wire logic [dbr_pkg::SPRW-1:0]        spr_addr_i,
    input  wire logic [dbr_pkg::XLEN-1:0]        source_operand_reg_i,
    input  wire logic                            spr_priv_i,
    output logic                                 spr_ack_o,
    output logic                                 spr_hit_o,
    output logic                                 spr_priv_fault_o,
    output logic [dbr_pkg::XLEN-1:0]             spr_rdata_o,
    // Reset kind report
    input  wire logic                            reset_note_i,
    input  wire logic [dbr_pkg::KINDW-1:0]       reset_kind_i,
    // Debug mode state
    input  wire logic                            internal_debug_en_i,
    input  wire logic                            external_debug_en_i,
    input  wire logic                            debug_exc_en_i,
    input  wire logic                            debug_interrupt_enable_i,
    // Detected debug events, one-cycle pulses
    input  wire logic                            evt_instr_complete_i,
    input  wire logic                            evt_branch_taken_i,
    input  wire logic                            evt_exception_i,
    input  wire logic                            evt_trap_i,
    input  wire logic                            evt_unconditional_i,
    input  wire logic [3:0]                      evt_iaddr_i,
    input  wire logic [1:0]                      evt_daddr_rd_i,
    input  wire logic [1:0]                      evt_daddr_wr_i,
    // Register contents toward the event logic
    output logic [dbr_pkg::XLEN-1:0]             debug_status_reg_o,
    output logic [3:0][dbr_pkg::XLEN-1:0]        instr_addr_cmp_o,
    output logic [1:0][dbr_pkg::XLEN-1:0]        data_addr_cmp_o,
    output logic [1:0][dbr_pkg::XLEN-1:0]        data_value_cmp_o
);

    dbr_pkg::dbr_main_state_t s_r;
    dbr_pkg::dbr_main_state_t s_nxt;

    dbr_stat_if st ();

    dbr_status u_status (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .st        (st.stat)
    );

    // =========================================================
    // Register number decode
    // =========================================================
    typedef enum logic [9:0] {
        SEL_NONE   = 10'h000,
        SEL_STATUS = 10'h001,
        SEL_INSTR_ADDR_CMP_1   = 10'h002,
        SEL_INSTR_ADDR_CMP_2   = 10'h004,
        SEL_INSTR_ADDR_CMP_3   = 10'h008,
        SEL_INSTR_ADDR_CMP_4   = 10'h010,
        SEL_DATA_ADDR_CMP_1   = 10'h020,
        SEL_DATA_ADDR_CMP_2   = 10'h040,
        SEL_DATA_VALUE_CMP_1   = 10'h080,
        SEL_DATA_VALUE_CMP_2   = 10'h100
    } dbr_sel_t;

    function automatic dbr_sel_t decode_spr(
        input logic [dbr_pkg::SPRW-1:0] a
    );
        case (a)
            dbr_pkg::SPR_STATUS: return SEL_STATUS;
            dbr_pkg::SPR_INSTR_ADDR_CMP_1:   return SEL_INSTR_ADDR_CMP_1;
            dbr_pkg::SPR_INSTR_ADDR_CMP_2:   return SEL_INSTR_ADDR_CMP_2;
            dbr_pkg::SPR_INSTR_ADDR_CMP_3:   return SEL_INSTR_ADDR_CMP_3;
            dbr_pkg::SPR_INSTR_ADDR_CMP_4:   return SEL_INSTR_ADDR_CMP_4;
            dbr_pkg::SPR_DATA_ADDR_CMP_1:   return SEL_DATA_ADDR_CMP_1;
            dbr_pkg::SPR_DATA_ADDR_CMP_2:   return SEL_DATA_ADDR_CMP_2;
            dbr_pkg::SPR_DATA_VALUE_CMP_1:   return SEL_DATA_VALUE_CMP_1;
            dbr_pkg::SPR_DATA_VALUE_CMP_2:   return SEL_DATA_VALUE_CMP_2;
            default:             return SEL_NONE;
        endcase
    endfunction : decode_spr

    dbr_sel_t                  sel;
    logic                      acc;
    logic                      wr;
    logic                      ic_quiet;
    logic [dbr_pkg::XLEN-1:0]  set_mask;
    logic [dbr_pkg::XLEN-1:0]  rd_val;

    // =========================================================
    // Event to flag mapping
    // =========================================================
    // Completion can fire every cycle; hide it when nobody acts on it
    assign ic_quiet = internal_debug_en_i && !debug_exc_en_i
                      && !external_debug_en_i;

    always_comb begin
        set_mask = '0;
        // Mode gating only on completion and branch-taken; every other event always sets its flag
        set_mask[dbr_pkg::BIT_IC]   = evt_instr_complete_i
                                      && !ic_quiet;
        set_mask[dbr_pkg::BIT_BT]   = evt_branch_taken_i
                                      && !ic_quiet;
        set_mask[dbr_pkg::BIT_EXC]  = evt_exception_i;
        set_mask[dbr_pkg::BIT_TRAP] = evt_trap_i;
        set_mask[dbr_pkg::BIT_UNC]  = evt_unconditional_i;
        set_mask[dbr_pkg::BIT_IA1]  = evt_iaddr_i[0];
        set_mask[dbr_pkg::BIT_IA2]  = evt_iaddr_i[1];
        set_mask[dbr_pkg::BIT_IA3]  = evt_iaddr_i[2];
        set_mask[dbr_pkg::BIT_IA4]  = evt_iaddr_i[3];
        set_mask[dbr_pkg::BIT_DR1]  = evt_daddr_rd_i[0];
        set_mask[dbr_pkg::BIT_DW1]  = evt_daddr_wr_i[0];
        set_mask[dbr_pkg::BIT_DR2]  = evt_daddr_rd_i[1];
        set_mask[dbr_pkg::BIT_DW2]  = evt_daddr_wr_i[1];
        // Imprecise only for events that actually recorded a flag
        set_mask[dbr_pkg::BIT_IMP]  = (|set_mask)
                                      && !debug_interrupt_enable_i;
    end

    assign st.set_mask = set_mask;

    // =========================================================
    // Special register access
    // =========================================================
    assign sel = decode_spr(spr_addr_i);
    assign acc = spr_valid_i && spr_priv_i && (sel != SEL_NONE);
    assign wr  = acc && spr_write_i;

    // Status write is a clear mask, never a load
    assign st.clr_mask = (wr && sel == SEL_STATUS)
                         ? source_operand_reg_i : '0;

    // Reset kind: taken once after release, then on each reset note
    assign st.kind_load = !s_r.kind_taken || reset_note_i;
    assign st.kind      = reset_kind_i;

    always_comb begin
        case (sel)
            SEL_STATUS: rd_val = st.status;
            SEL_INSTR_ADDR_CMP_1:   rd_val = s_r.iac[0];
            SEL_INSTR_ADDR_CMP_2:   rd_val = s_r.iac[1];
            SEL_INSTR_ADDR_CMP_3:   rd_val = s_r.iac[2];
            SEL_INSTR_ADDR_CMP_4:   rd_val = s_r.iac[3];
            SEL_DATA_ADDR_CMP_1:   rd_val = s_r.dac[0];
            SEL_DATA_ADDR_CMP_2:   rd_val = s_r.dac[1];
            SEL_DATA_VALUE_CMP_1:   rd_val = s_r.dvc[0];
            SEL_DATA_VALUE_CMP_2:   rd_val = s_r.dvc[1];
            default:    rd_val = '0;
        endcase
    end

    always_comb begin
        s_nxt            = s_r;
        s_nxt.kind_taken = 1'b1;
        s_nxt.ack        = spr_valid_i;
        s_nxt.hit        = spr_valid_i && (sel != SEL_NONE);
        // Unprivileged access neither reads nor writes
        s_nxt.fault      = spr_valid_i && !spr_priv_i;
        s_nxt.rdata      = (acc && !spr_write_i) ? rd_val : '0;
        if (wr) begin
            // Stored as written; alignment is software's duty
            case (sel)
                SEL_INSTR_ADDR_CMP_1: s_nxt.iac[0] = source_operand_reg_i;
                SEL_INSTR_ADDR_CMP_2: s_nxt.iac[1] = source_operand_reg_i;
                SEL_INSTR_ADDR_CMP_3: s_nxt.iac[2] = source_operand_reg_i;
                SEL_INSTR_ADDR_CMP_4: s_nxt.iac[3] = source_operand_reg_i;
                SEL_DATA_ADDR_CMP_1: s_nxt.dac[0] = source_operand_reg_i;
                SEL_DATA_ADDR_CMP_2: s_nxt.dac[1] = source_operand_reg_i;
                SEL_DATA_VALUE_CMP_1: s_nxt.dvc[0] = source_operand_reg_i;
                SEL_DATA_VALUE_CMP_2: s_nxt.dvc[1] = source_operand_reg_i;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r.iac        <= {NUM_IAC{dbr_pkg::CMP_RESET}};
            s_r.dac        <= {NUM_DAC{dbr_pkg::CMP_RESET}};
            s_r.dvc        <= {NUM_DVC{dbr_pkg::CMP_RESET}};
            s_r.rdata      <= '0;
            s_r.ack        <= 1'b0;
            s_r.fault      <= 1'b0;
            s_r.hit        <= 1'b0;
            s_r.kind_taken <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // =========================================================
    // Outputs, all from flip-flops
    // =========================================================
    assign spr_ack_o          = s_r.ack;
    assign spr_hit_o          = s_r.hit;
    assign spr_priv_fault_o   = s_r.fault;
    assign spr_rdata_o        = s_r.rdata;
    assign debug_status_reg_o = st.status;
    assign instr_addr_cmp_o   = s_r.iac;
    assign data_addr_cmp_o    = s_r.dac;
    assign data_value_cmp_o   = s_r.dvc;

endmodule : dbr_regs

// *** logic/dbr_pkg.sv ***
// Contract
// - 32-bit debug status register; hardware sets flags on detected events.
// - Events set status flags even when every debug mode is switched off.
// - Last-reset bits 22:23 change only on reset: 00 none .. 11 system.
// - Bit 0 instruction-complete, bit 1 branch-taken; one means occurred.
// - Bit 2 exception-taken, bit 3 trap instruction, bit 4 unconditional.
// - Instruction-address compares one to four report in bits 5, 6, 12, 13.
// - Data-address compares: bit 7 1-read, 8 1-write, 9 2-read, 10 2-write.
// - Bit 11 set by events with debug interrupts disabled, never when enabled.
// - Status write clears each event flag written one, keeps each bit written zero.
// - Writes never load status, they only clear; reads show the flags.
// - Status register is privileged special-purpose register 0x3f0.
// - Four 32-bit instruction compares at 0x3f4, 0x3f5, 0x3b4, 0x3b5.
// - Two 32-bit data-address compares at 0x3f6, 0x3f7, any byte address.
// - Two 32-bit data-value compare registers at 0x3b6, 0x3b7, any value.
// - Compare registers: privileged, read and written by move instructions.
// - No complete/branch flag with internal on, exceptions off, external off.
package dbr_pkg;

    localparam int XLEN      = 32;
    localparam int SPRW      = 10;
    localparam int NUM_IAC   = 4;
    localparam int NUM_DAC   = 2;
    localparam int NUM_DVC   = 2;
    localparam int KINDW     = 2;

    // =========================================================
    // Special-purpose register numbers
    // =========================================================
    localparam logic [SPRW-1:0] SPR_STATUS = 10'h3f0;
    localparam logic [SPRW-1:0] SPR_INSTR_ADDR_CMP_1   = 10'h3f4;
    localparam logic [SPRW-1:0] SPR_INSTR_ADDR_CMP_2   = 10'h3f5;
    localparam logic [SPRW-1:0] SPR_INSTR_ADDR_CMP_3   = 10'h3b4;
    localparam logic [SPRW-1:0] SPR_INSTR_ADDR_CMP_4   = 10'h3b5;
    localparam logic [SPRW-1:0] SPR_DATA_ADDR_CMP_1   = 10'h3f6;
    localparam logic [SPRW-1:0] SPR_DATA_ADDR_CMP_2   = 10'h3f7;
    localparam logic [SPRW-1:0] SPR_DATA_VALUE_CMP_1   = 10'h3b6;
    localparam logic [SPRW-1:0] SPR_DATA_VALUE_CMP_2   = 10'h3b7;

    // =========================================================
    // Status fields, big-endian numbering: bit 0 is the MSB
    // =========================================================
    function automatic int be_bit(input int n);
        return XLEN - 1 - n;
    endfunction : be_bit

    localparam int BIT_IC    = be_bit(0);
    localparam int BIT_BT    = be_bit(1);
    localparam int BIT_EXC   = be_bit(2);
    localparam int BIT_TRAP  = be_bit(3);
    localparam int BIT_UNC   = be_bit(4);
    localparam int BIT_IA1   = be_bit(5);
    localparam int BIT_IA2   = be_bit(6);
    localparam int BIT_DR1   = be_bit(7);
    localparam int BIT_DW1   = be_bit(8);
    localparam int BIT_DR2   = be_bit(9);
    localparam int BIT_DW2   = be_bit(10);
    localparam int BIT_IMP   = be_bit(11);
    localparam int BIT_IA3   = be_bit(12);
    localparam int BIT_IA4   = be_bit(13);
    localparam int BIT_KIND  = be_bit(23);

    // Only event flags may be cleared; kind and reserved bits never
    localparam logic [XLEN-1:0] FLAG_MASK = 32'hfffc0000;

    localparam logic [KINDW-1:0] KIND_NONE   = 2'h0;
    localparam logic [KINDW-1:0] KIND_PROC   = 2'h1;
    localparam logic [KINDW-1:0] KIND_CHIP   = 2'h2;
    localparam logic [KINDW-1:0] KIND_SYSTEM = 2'h3;

    localparam logic [XLEN-1:0] CMP_RESET    = 32'h00000000;
    localparam logic [XLEN-1:0] STATUS_RESET = 32'h00000000;

    typedef struct packed {
        logic [NUM_IAC-1:0][XLEN-1:0] iac;
        logic [NUM_DAC-1:0][XLEN-1:0] dac;
        logic [NUM_DVC-1:0][XLEN-1:0] dvc;
        logic [XLEN-1:0]              rdata;
        logic                         ack;
        logic                         fault;
        logic                         hit;
        logic                         kind_taken;
    } dbr_main_state_t;

    typedef struct packed {
        logic [XLEN-1:0] status;
    } dbr_stat_state_t;

endpackage : dbr_pkg

// *** logic/dbr_stat_if.sv ***
interface dbr_stat_if;
    logic [dbr_pkg::XLEN-1:0]  set_mask;
    logic [dbr_pkg::XLEN-1:0]  clr_mask;
    logic                      kind_load;
    logic [dbr_pkg::KINDW-1:0] kind;
    logic [dbr_pkg::XLEN-1:0]  status;

    modport ctl (
        output set_mask,
        output clr_mask,
        output kind_load,
        output kind,
        input  status
    );
    modport stat (
        input  set_mask,
        input  clr_mask,
        input  kind_load,
        input  kind,
        output status
    );
endinterface : dbr_stat_if

// *** logic/dbr_status.sv ***
module dbr_status (
    input  wire logic   clk_i,
    input  wire logic   reset_n_i,
    dbr_stat_if.stat    st
);

    dbr_pkg::dbr_stat_state_t s_r;
    dbr_pkg::dbr_stat_state_t s_nxt;

    // =========================================================
    // Flag update: set wins over a same-cycle clear
    // =========================================================
    always_comb begin
        s_nxt = s_r;
        s_nxt.status = (s_r.status
                        & ~(st.clr_mask & dbr_pkg::FLAG_MASK))
                       | (st.set_mask & dbr_pkg::FLAG_MASK);
        if (st.kind_load) begin
            s_nxt.status[dbr_pkg::BIT_KIND +: dbr_pkg::KINDW] = st.kind;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '{status: dbr_pkg::STATUS_RESET};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign st.status = s_r.status;

endmodule : dbr_status

// *** dv/dbr_properties.sv ***
module dbr_chk (
    input wire logic                              clk_i,
    input wire logic                              reset_n_i,
    input wire logic                              spr_valid_i,
    input wire logic                              spr_write_i,
    input wire logic [dbr_pkg::SPRW-1:0]          spr_addr_i,
    input wire logic [dbr_pkg::XLEN-1:0]          source_operand_reg_i,
    input wire logic                              spr_priv_i,
    input wire logic                              spr_ack_o,
    input wire logic                              spr_priv_fault_o,
    input wire logic [dbr_pkg::XLEN-1:0]          spr_rdata_o,
    input wire logic                              reset_note_i,
    input wire logic [dbr_pkg::KINDW-1:0]         reset_kind_i,
    input wire logic                              internal_debug_en_i,
    input wire logic                              external_debug_en_i,
    input wire logic                              debug_exc_en_i,
    input wire logic                              debug_interrupt_enable_i,
    input wire logic                              evt_instr_complete_i,
    input wire logic                              evt_trap_i,
    input wire logic [3:0]                        evt_iaddr_i,
    input wire logic [1:0]                        evt_daddr_wr_i,
    input wire logic [dbr_pkg::XLEN-1:0]          debug_status_reg_o,
    input wire logic [3:0][dbr_pkg::XLEN-1:0]     instr_addr_cmp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // ==========================================================
    // Register port
    // ==========================================================
    sequence s_instr_addr_cmp_1_rd;
        spr_valid_i && !spr_write_i && spr_priv_i
            && spr_addr_i == dbr_pkg::SPR_INSTR_ADDR_CMP_1;
    endsequence
    sequence s_clr_trap;
        spr_valid_i && spr_write_i && spr_priv_i && !evt_trap_i
            && spr_addr_i == dbr_pkg::SPR_STATUS && source_operand_reg_i[28];
    endsequence
    property p_ack;
        spr_valid_i |=> spr_ack_o;
    endproperty
    property p_fault;
        spr_valid_i && !spr_priv_i |=> spr_priv_fault_o && spr_rdata_o == '0;
    endproperty
    property p_rd;
        s_instr_addr_cmp_1_rd |=> spr_rdata_o == $past(instr_addr_cmp_o[0]);
    endproperty
    property p_clr;
        s_clr_trap |=> !debug_status_reg_o[28];
    endproperty
    a_ack: assert property (p_ack)
        else $error("no ack after request");
    a_fault: assert property (p_fault)
        else $error("no privilege fault");
    a_rd: assert property (p_rd)
        else $error("compare read mismatch");
    a_clr: assert property (p_clr)
        else $error("status bit not cleared");

    // ==========================================================
    // Status flags
    // ==========================================================
    sequence s_ic_gated;
        evt_instr_complete_i && internal_debug_en_i && !debug_exc_en_i
            && !external_debug_en_i && !debug_status_reg_o[31];
    endsequence
    property p_trap;
        evt_trap_i |=> debug_status_reg_o[28];
    endproperty
    property p_iaddr;
        evt_iaddr_i[2] |=> debug_status_reg_o[19];
    endproperty
    property p_dw2;
        evt_daddr_wr_i[1] |=> debug_status_reg_o[21];
    endproperty
    property p_ide;
        $rose(debug_status_reg_o[20]) |-> !$past(debug_interrupt_enable_i);
    endproperty
    property p_resv;
        (debug_status_reg_o & 32'h0003fcff) == '0;
    endproperty
    property p_ic;
        s_ic_gated |=> !debug_status_reg_o[31];
    endproperty
    property p_kind;
        reset_note_i |=> debug_status_reg_o[9:8] == $past(reset_kind_i);
    endproperty
    a_trap: assert property (p_trap)
        else $error("trap flag missing");
    a_iaddr: assert property (p_iaddr)
        else $error("iaddr 3 flag missing");
    a_dw2: assert property (p_dw2)
        else $error("daddr 2 write flag");
    a_ide: assert property (p_ide)
        else $error("imprecise flag set");
    a_resv: assert property (p_resv)
        else $error("reserved bit set");
    a_ic: assert property (p_ic)
        else $error("gated flag was set");
    a_kind: assert property (p_kind)
        else $error("reset kind wrong");
endmodule : dbr_chk

bind dbr_regs dbr_chk u_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .spr_valid_i(spr_valid_i),
    .spr_write_i(spr_write_i), .spr_addr_i(spr_addr_i),
    .source_operand_reg_i(source_operand_reg_i), .spr_priv_i(spr_priv_i),
    .spr_ack_o(spr_ack_o), .spr_priv_fault_o(spr_priv_fault_o),
    .spr_rdata_o(spr_rdata_o), .reset_note_i(reset_note_i),
    .reset_kind_i(reset_kind_i), .internal_debug_en_i(internal_debug_en_i),
    .external_debug_en_i(external_debug_en_i),
    .debug_exc_en_i(debug_exc_en_i),
    .debug_interrupt_enable_i(debug_interrupt_enable_i),
    .evt_instr_complete_i(evt_instr_complete_i), .evt_trap_i(evt_trap_i),
    .evt_iaddr_i(evt_iaddr_i), .evt_daddr_wr_i(evt_daddr_wr_i),
    .debug_status_reg_o(debug_status_reg_o),
    .instr_addr_cmp_o(instr_addr_cmp_o));

// *** dv/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [9:0]  a;
        logic [31:0] d;
        logic [31:0] r;
        logic        h;
    } dbr_row_t;
    logic             clk_i = 0, reset_n_i = 0, spr_valid_i = 0;
    logic             spr_write_i = 0, spr_priv_i = 0, reset_note_i = 0;
    logic [9:0]       spr_addr_i = '0;
    logic [31:0]      source_operand_reg_i = '0;
    logic [1:0]       reset_kind_i = 2'h2;
    logic             internal_debug_en_i = 0, external_debug_en_i = 0;
    logic             debug_exc_en_i = 0, debug_interrupt_enable_i = 1;
    logic [13:0]      ev = '0;
    logic             spr_ack_o, spr_hit_o, spr_priv_fault_o;
    logic [31:0]      spr_rdata_o, st;
    logic [3:0][31:0] iac;
    logic [1:0][31:0] dac, dvc;
    logic [7:0][31:0] cmpw;
    assign cmpw = {dvc, dac, iac};
    int               err_total = 0, cmp_count = 0;
    // Last two rows: status ignores written ones, unmapped reads zero
    dbr_row_t rows [10] = '{
        '{10'h3f4, 32'h10000004, 32'h10000004, 1'b1},
        '{10'h3f5, 32'h2000abc8, 32'h2000abc8, 1'b1},
        '{10'h3b4, 32'hfffffffc, 32'hfffffffc, 1'b1},
        '{10'h3b5, 32'h00000010, 32'h00000010, 1'b1},
        '{10'h3f6, 32'h00000003, 32'h00000003, 1'b1},
        '{10'h3f7, 32'hffffffff, 32'hffffffff, 1'b1},
        '{10'h3b6, 32'ha5a55a5a, 32'ha5a55a5a, 1'b1},
        '{10'h3b7, 32'h00000001, 32'h00000001, 1'b1},
        '{10'h3f0, 32'hffffffff, 32'h00000200, 1'b1},
        '{10'h3f1, 32'h12345678, 32'h00000000, 1'b0}};

    dbr_regs u_dbr_regs (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .spr_valid_i(spr_valid_i),
        .spr_write_i(spr_write_i), .spr_addr_i(spr_addr_i),
        .source_operand_reg_i(source_operand_reg_i),
        .spr_priv_i(spr_priv_i), .spr_ack_o(spr_ack_o),
        .spr_hit_o(spr_hit_o), .spr_priv_fault_o(spr_priv_fault_o),
        .spr_rdata_o(spr_rdata_o), .reset_note_i(reset_note_i),
        .reset_kind_i(reset_kind_i),
        .internal_debug_en_i(internal_debug_en_i),
        .external_debug_en_i(external_debug_en_i),
        .debug_exc_en_i(debug_exc_en_i),
        .debug_interrupt_enable_i(debug_interrupt_enable_i),
        .evt_instr_complete_i(ev[0]), .evt_branch_taken_i(ev[1]),
        .evt_exception_i(ev[2]), .evt_trap_i(ev[3]),
        .evt_unconditional_i(ev[4]),
        .evt_iaddr_i({ev[13], ev[12], ev[6], ev[5]}),
        .evt_daddr_rd_i({ev[9], ev[7]}), .evt_daddr_wr_i({ev[10], ev[8]}),
        .debug_status_reg_o(st), .instr_addr_cmp_o(iac),
        .data_addr_cmp_o(dac), .data_value_cmp_o(dvc));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Answer stands one cycle: sampled just after the ack edge
    task automatic special_purpose_reg(input logic w, input logic [9:0] a,
                       input logic [31:0] d, input logic p);
        @(posedge clk_i);
        spr_valid_i <= 1'b1;
        spr_write_i <= w;
        spr_addr_i <= a;
        source_operand_reg_i <= d;
        spr_priv_i <= p;
        @(posedge clk_i);
        spr_valid_i <= 1'b0;
        #1;
    endtask : special_purpose_reg

    task automatic pulse(input logic [13:0] e);
        @(posedge clk_i);
        ev <= e;
        @(posedge clk_i);
        ev <= '0;
        #1;
    endtask : pulse

    task automatic wrap_up;
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk("status after reset", 32'h00000200, st);
        foreach (rows[i]) begin
            special_purpose_reg(1'b1, rows[i].a, rows[i].d, 1'b1);
            chk("write ack", 32'h1, {31'h0, spr_ack_o});
            special_purpose_reg(1'b0, rows[i].a, 32'h0, 1'b1);
            chk("read data", rows[i].r, spr_rdata_o);
            chk("hit", {31'h0, rows[i].h}, {31'h0, spr_hit_o});
        end
        // Compare words face the event logic directly, not only via reads
        for (int i = 0; i < 8; i++) begin
            chk("compare output", rows[i].d, cmpw[i]);
        end
        for (int k = 0; k < 14; k++) begin
            if (k != 11) begin
                pulse(14'h1 << k);
                chk("event flag", 32'h200 | (32'h1 << (31 - k)), st);
                special_purpose_reg(1'b1, 10'h3f0, 32'h1 << (31 - k), 1'b1);
                chk("flag cleared", 32'h00000200, st);
            end
        end
        @(posedge clk_i);
        debug_interrupt_enable_i <= 1'b0;
        pulse(14'h8);
        chk("imprecise flag", 32'h10100200, st);
        special_purpose_reg(1'b1, 10'h3f0, 32'h10000000, 1'b1);
        chk("partial clear", 32'h00100200, st);
        // Event and clear of one flag in one cycle: the set must win
        fork
            pulse(14'h8);
            special_purpose_reg(1'b1, 10'h3f0, 32'h10000000, 1'b1);
        join
        chk("set over clear", 32'h10100200, st);
        special_purpose_reg(1'b1, 10'h3f0, 32'hffffffff, 1'b1);
        chk("full clear", 32'h00000200, st);
        @(posedge clk_i);
        internal_debug_en_i <= 1'b1;
        debug_interrupt_enable_i <= 1'b1;
        pulse(14'h3);
        chk("gated ic bt", 32'h00000200, st);
        @(posedge clk_i);
        debug_exc_en_i <= 1'b1;
        pulse(14'h3);
        chk("ic bt", 32'hc0000200, st);
        special_purpose_reg(1'b1, 10'h3f0, 32'hffffffff, 1'b1);
        @(posedge clk_i);
        debug_exc_en_i <= 1'b0;
        external_debug_en_i <= 1'b1;
        pulse(14'h1);
        chk("ic external", 32'h80000200, st);
        special_purpose_reg(1'b1, 10'h3f0, 32'hffffffff, 1'b1);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            reset_note_i <= 1'b1;
            reset_kind_i <= k[1:0];
            @(posedge clk_i);
            reset_note_i <= 1'b0;
            #1;
            chk("reset kind", {22'h0, k[1:0], 8'h0}, st);
        end
        pulse(14'h10);
        chk("kind kept", 32'h08000300, st);
        special_purpose_reg(1'b1, 10'h3f4, 32'hdeadbeec, 1'b0);
        chk("priv fault", 32'h1, {31'h0, spr_priv_fault_o});
        chk("iac kept", rows[0].d, iac[0]);
        // Reset in mid-run: everything clears, kind reloads on release
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        reset_kind_i <= 2'h1;
        #1;
        chk("status in reset", 32'h00000000, st);
        chk("iac in reset", 32'h00000000, iac[0]);
        @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk("kind after reset", 32'h00000100, st);
        wrap_up();
    end
endmodule : testbench
